/* File: verilog/uft_regs.vh */
// register offsets, field positions, reset values and timing for the frame timing block
`ifndef UFT_REGS_VH
`define UFT_REGS_VH

`define UFT_ADDR_W            32
`define UFT_OFF_FRAME_LEFT    32'hfff05038
`define UFT_OFF_FRAME_COUNT   32'hfff0503c
`define UFT_OFF_PERIODIC      32'hfff05040
`define UFT_OFF_SLOW_CUTOFF   32'hfff05044

`define UFT_LEFT_W            14
`define UFT_INDEX_W           16
`define UFT_PERIODIC_W        14
`define UFT_CUTOFF_W          12
`define UFT_TOGGLE_BIT        31

`define UFT_RST_LEFT          14'h0000
`define UFT_RST_INDEX         16'h0000
`define UFT_RST_PERIODIC      14'h0000
`define UFT_RST_CUTOFF        12'h628
`define UFT_INDEX_WRAP        16'h000f

`define UFT_SYS_CLK_KHZ       16'h4e20
`define UFT_BIT_CLK_KHZ       16'h2ee0
`define UFT_PHASE_W           16

`endif

/* File: verilog/uft_frame_timing.v */
// frame timing block: frame remaining counter, frame number, periodic start, slow cutoff
// Function
// - count down once per bit time while running
// - reload from frame length at zero
// - load on entering running state
// - copy length toggle into remaining toggle on load
// - advance frame index on each load
// - frame index wraps from 000fh to zero
// - periodic begin value held for list processor
// - slow cutoff value, reset 628h, for frame management
// - reload uses length value as bit times minus one
`timescale 1ns/1ps
`include "uft_regs.vh"

module uft_frame_timing (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire [31:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  input  wire        bus_running_state,
  input  wire [13:0] frame_length_value,
  input  wire        length_change_toggle,
  output wire        bit_tick,
  output wire        frame_load,
  output reg  [13:0] frame_time_left_count,
  output reg         remaining_toggle,
  output reg  [15:0] frame_index,
  output reg  [13:0] periodic_begin_value,
  output reg  [11:0] slow_cutoff_value,
  output wire        periodic_start_due,
  output wire        slow_start_allowed
);

  // fractional divider: adds 12000 per cycle, tick on each wrap past 20000
  localparam [15:0] PHASE_STEP = `UFT_BIT_CLK_KHZ;
  localparam [15:0] PHASE_MOD  = `UFT_SYS_CLK_KHZ;

  reg  [15:0] phase_reg;
  reg  [15:0] phase_next;
  reg         tick_reg;
  reg         running_reg;
  reg  [13:0] left_next;
  reg  [15:0] index_next;
  reg  [31:0] rdata_next;
  wire [16:0] phase_sum;
  wire        enter_run;
  wire        hit_zero;

  assign phase_sum = {1'b0, phase_reg} + {1'b0, PHASE_STEP};
  assign bit_tick  = tick_reg;

  always @*
  begin
    if (phase_sum >= {1'b0, PHASE_MOD})
      phase_next = phase_sum[15:0] - PHASE_MOD;
    else
      phase_next = phase_sum[15:0];
  end

  // 12 mhz bit period enable from the 20 mhz system clock
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_reg <= 16'h0000;
      tick_reg  <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      tick_reg  <= (phase_sum >= {1'b0, PHASE_MOD});
    end
  end

  assign enter_run  = bus_running_state & ~running_reg;
  assign hit_zero   = running_reg & bus_running_state & bit_tick
                      & (frame_time_left_count == 14'h0000);
  assign frame_load = enter_run | hit_zero;

  always @*
  begin
    left_next = frame_time_left_count;
    if (frame_load)
      left_next = frame_length_value;
    else if (bus_running_state && running_reg && bit_tick)
      left_next = frame_time_left_count - 14'h0001;
  end

  always @*
  begin
    if (frame_index == `UFT_INDEX_WRAP)
      index_next = 16'h0000;
    else
      index_next = frame_index + 16'h0001;
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      running_reg           <= 1'b0;
      frame_time_left_count <= `UFT_RST_LEFT;
      remaining_toggle      <= 1'b0;
      frame_index           <= `UFT_RST_INDEX;
    end
    else
    begin
      running_reg           <= bus_running_state;
      frame_time_left_count <= left_next;
      if (frame_load)
      begin
        remaining_toggle <= length_change_toggle;
        frame_index      <= index_next;
      end
    end
  end

  // software-writable scheduling values
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      periodic_begin_value <= `UFT_RST_PERIODIC;
      slow_cutoff_value    <= `UFT_RST_CUTOFF;
    end
    else if (reg_write)
    begin
      if (reg_addr == `UFT_OFF_PERIODIC)
        periodic_begin_value <= reg_wdata[13:0];
      if (reg_addr == `UFT_OFF_SLOW_CUTOFF)
        slow_cutoff_value <= reg_wdata[11:0];
    end
  end

  // periodic work starts once the remaining count falls to the begin point
  assign periodic_start_due = bus_running_state
                              & (frame_time_left_count <= periodic_begin_value);
  assign slow_start_allowed = bus_running_state
                              & (frame_time_left_count >= {2'b00, slow_cutoff_value});

  always @*
  begin
    rdata_next = 32'h00000000;
    case (reg_addr)
      `UFT_OFF_FRAME_LEFT:
        rdata_next = {remaining_toggle, 17'h00000, frame_time_left_count};
      `UFT_OFF_FRAME_COUNT:
        rdata_next = {16'h0000, frame_index};
      `UFT_OFF_PERIODIC:
        rdata_next = {18'h00000, periodic_begin_value};
      `UFT_OFF_SLOW_CUTOFF:
        rdata_next = {20'h00000, slow_cutoff_value};
      default:
        rdata_next = 32'h00000000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else if (reg_read)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 32'h00000000;
  end

endmodule // uft_frame_timing

/* File: dv/uft_len_src.sv */
// driver-side model that programs the frame length
`timescale 1ns/1ps
module uft_len_src (
  input  wire        sys_clk,
  input  wire        set_en,
  input  wire [13:0] set_len,
  output reg  [13:0] frame_length_value,
  output reg         length_change_toggle
);
  initial frame_length_value = 14'h2edf;
  initial length_change_toggle = 1'b0;
  always @(posedge sys_clk)
  begin
    if (set_en)
    begin
      frame_length_value <= set_len;
      length_change_toggle <= ~length_change_toggle;
    end
  end
endmodule // uft_len_src

/* File: dv/uft_frame_timing_properties.sv */
// frame timing checker
`timescale 1ns/1ps
module uft_ft_props (
  input wire        sys_clk,
  input wire        rst,
  input wire        bus_running_state,
  input wire [13:0] frame_length_value,
  input wire        length_change_toggle,
  input wire        bit_tick,
  input wire        frame_load,
  input wire [13:0] frame_time_left_count,
  input wire        remaining_toggle,
  input wire [15:0] frame_index,
  input wire [11:0] slow_cutoff_value,
  input wire        slow_start_allowed
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_entry; !bus_running_state ##1 bus_running_state; endsequence
  chk_entry_load: assert property (s_entry |-> frame_load) else $error("entry");
  chk_load_value: assert property (frame_load |=>
    frame_time_left_count == $past(frame_length_value)) else $error("load");
  chk_toggle_copy: assert property (frame_load |=>
    remaining_toggle == $past(length_change_toggle)) else $error("toggle");
  chk_index_step: assert property (frame_load && frame_index != 16'hf |=>
    frame_index == $past(frame_index) + 16'h1) else $error("index");
  chk_index_wrap: assert property (frame_load && frame_index == 16'hf |=>
    frame_index == 16'h0) else $error("wrap");
  chk_count_down: assert property (bus_running_state && bit_tick && !frame_load |=>
    frame_time_left_count == $past(frame_time_left_count) - 14'h1) else $error("dec");
  chk_end_reload: assert property (bus_running_state && bit_tick &&
    frame_time_left_count == 14'h0 |-> frame_load) else $error("end");
  chk_slow_allow: assert property (slow_start_allowed == (bus_running_state &&
    frame_time_left_count >= slow_cutoff_value)) else $error("slow");
endmodule // uft_ft_props
bind uft_frame_timing uft_ft_props uft_ft_props_i (.*);

/* File: dv/test_uft_frame_timing.sv */
// self-checking bench for the frame timing block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("mismatch %0t value differs", $time); end end
module test_uft_frame_timing;
  reg         clk = 0;
  reg         rst = 1;
  reg  [31:0] ad = 0;
  reg  [31:0] wd = 0;
  reg         we = 0;
  reg         re = 0;
  reg         run = 0;
  reg         se = 0;
  reg  [13:0] sl = 0;
  wire [31:0] rd_q;
  wire [13:0] fl, left, pb;
  wire [15:0] idx;
  wire [11:0] sc;
  wire        ft, tk, ld, rt, ok, pd;
  integer     n_fail = 0, total_checks = 0, i, n;
  always #25 clk = ~clk;
  uft_len_src uft_len_src_i (.sys_clk(clk), .set_en(se), .set_len(sl),
    .frame_length_value(fl), .length_change_toggle(ft));
  uft_frame_timing uft_frame_timing_i (.sys_clk(clk), .rst(rst), .reg_addr(ad),
    .reg_wdata(wd), .reg_write(we), .reg_read(re), .reg_rdata(rd_q),
    .bus_running_state(run), .frame_length_value(fl), .length_change_toggle(ft),
    .bit_tick(tk), .frame_load(ld), .frame_time_left_count(left), .remaining_toggle(rt),
    .frame_index(idx), .periodic_begin_value(pb), .slow_cutoff_value(sc),
    .periodic_start_due(pd), .slow_start_allowed(ok));
  task step; begin @(posedge clk); #1; end endtask
  task acc(input w, input [31:0] a, input [31:0] d);
  begin
    @(posedge clk);
    ad <= a;
    wd <= d;
    we <= w;
    re <= !w;
    @(posedge clk);
    we <= 0;
    re <= 0;
    #1 if (!w) `CHK(rd_q, d)
  end
  endtask
  task t_regs;
  begin
    acc(0, 32'hfff05038, 0);
    acc(0, 32'hfff05040, 0);
    acc(0, 32'hfff05044, 32'h628);
    acc(1, 32'hfff05040, -1);
    acc(1, 32'hfff05044, 3);
    acc(1, 32'hfff0503c, -1);
    acc(0, 32'hfff05044, 32'h3);
    acc(0, 32'hfff05040, 32'h3fff);
    acc(0, 32'hfff0503c, 0);
    acc(0, 32'hfff05048, 0);
    $display("regs done");
  end
  endtask
  task t_frame;
  begin
    acc(1, 32'hfff05040, 3);
    @(posedge clk);
    sl <= 5;
    se <= 1;
    @(posedge clk);
    se <= 0;
    run <= 1;
    step;
    `CHK({rt, idx, left, pd}, {1'b1, 16'h1, 14'h5, 1'b0})
    n = 0;
    for (i = 0; i < 40 && ld !== 1; i++) begin n += tk; step; end
    `CHK(n + tk, 6)
    for (i = 0; i < 400 && idx !== 15; i++) step;
    for (i = 0; i < 40 && ld !== 1; i++) step;
    step;
    `CHK({idx, left, ok}, {16'h0, 14'h5, 1'b1})
    for (i = 0; i < 40 && left !== 2; i++) step;
    `CHK({ok, pd}, 2'b01)
    run <= 0;
    n = left;
    repeat (4) step;
    `CHK(left, n[13:0])
    acc(0, 32'hfff05038, {1'b1, 17'h0, n[13:0]});
    $display("frame done");
  end
  endtask
  task conclude;
  begin
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_regs;
    t_frame;
    conclude;
  end
  initial
  begin
    #100000;
    n_fail++;
    conclude;
  end
endmodule // test_uft_frame_timing
